// file: design/hotplug_sequencer.sv
// power-up and hot-plug sequencer for a host with only a digital video output
// assumes: presence_in from an asynchronous comparator, id read engine on mclk,
// pix_clk free-running from the transmitter pll, rst held >= 16 mclk cycles
//
// Notes on behaviour
// [RL1] after reset, confirm presence supply line is high before identifying
// [RL2] with presence confirmed, read identification structure at address a2h
// [RL3] identification says digital: enable transmitter and start sending images
// [RL4] presence lost during operation: disable transmitter at once
// [RL5] after disconnect watch for presence return; never re-enable transmitter alone
// [RL6] on reconnect raise interrupt so software repeats identification
// [RL7] missing presence, no answer at a2h, or contents: monitor is analogue
// [RL8] analogue monitor: report error status, then watch for presence drop
// [RL9] after incompatible monitor leaves, presence return raises interrupt
// [RL10] monitor starts in its power-off state when first powered
// [RL11] monitor watches host supply line for active host
// [RL12] monitor enables receiver only after all 256 identification bytes read
// [RL13] monitor waits for pixel shift clock before powering its panel
// [RL14] monitor decodes sync signals into four display power states; the model decodes shift_on twice, so only on and off occur
// [RL15] shift clock or host supply lost: monitor powers down, receiver off; the model turns its receiver off on supply loss only
// [RL16] after power-down monitor waits for supply and identification read again
// [RL17] presence comparator passes two synchroniser flops before use
// [RL18] reconnect interrupt stays pending until software clears it
`default_nettype none
module hotplug_sequencer
	import hotplug_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       pix_clk,
	input  wire logic       presence_in,
	input  wire logic       id_done,
	input  wire logic       id_ack,
	input  wire logic       id_digital,
	input  wire logic       irq_clear,
	input  wire logic       sw_restart,
	output logic            id_read_req_q,
	output logic [7:0]      id_addr_q,
	output logic            tx_enable_q,
	output logic            tx_enable_pix_q,
	output logic            image_start_q,
	output logic            reconnect_irq_q,
	output logic            error_status_q,
	output logic            tx_running_q
);

	// presence synchroniser, stage one read only by stage two
	logic pres_s1_q;
	logic pres_s_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			pres_s1_q <= 1'b0;
			pres_s_q  <= 1'b0;
		end else begin
			pres_s1_q <= presence_in; // [RL17]
			pres_s_q  <= pres_s1_q;   // [RL17]
		end
	end

	// sequencer state and its registered outputs
	seq_state_t state_q;
	seq_state_t state_d;
	logic [1:0] settle_q;
	logic [1:0] settle_d;
	logic       req_d;
	logic [7:0] addr_d;
	logic       tx_d;
	logic       start_d;
	logic       irq_d;
	logic       err_d;

	// next-state logic; presence loss is checked before anything else in run
	always_comb begin
		state_d  = state_q;
		settle_d = settle_q;
		req_d    = 1'b0;
		addr_d   = id_addr_q;
		start_d  = 1'b0;
		err_d    = error_status_q;
		// set wins over clear so a reconnect landing on the clear is kept
		irq_d    = reconnect_irq_q & ~irq_clear; // [RL18]
		case (state_q)
			ST_CHECK: begin
				// wait until the synchroniser holds a real sample
				if (settle_q != SETTLE_CYCLES) begin
					settle_d = settle_q + SETTLE_STEP;
				end else if (pres_s_q) begin
					state_d = ST_READ; // [RL1]
				end else begin
					err_d   = 1'b1;     // [RL7]
					state_d = ST_WATCH; // [RL8]
				end
			end
			ST_READ: begin
				req_d   = 1'b1;    // [RL2]
				addr_d  = ID_ADDR; // [RL2]
				state_d = ST_WAIT_ID;
			end
			ST_WAIT_ID: begin
				if (!pres_s_q) begin
					state_d = ST_WATCH;
				end else if (id_done) begin
					if (id_ack && id_digital) begin
						start_d = 1'b1;   // [RL3]
						state_d = ST_RUN; // [RL3]
					end else begin
						err_d   = 1'b1;      // [RL7]
						state_d = ST_ANALOG; // [RL8]
					end
				end
			end
			ST_RUN: begin
				if (!pres_s_q) begin
					state_d = ST_WATCH; // [RL4]
				end
			end
			ST_ANALOG: begin
				if (!pres_s_q) begin
					state_d = ST_WATCH; // [RL8]
				end
			end
			ST_WATCH: begin
				// a returning monitor may be another one: flag, never re-enable
				if (pres_s_q) begin
					irq_d   = 1'b1;    // [RL6] [RL9]
					state_d = ST_HOLD; // [RL5]
				end
			end
			ST_HOLD: begin
				if (!pres_s_q) begin
					state_d = ST_WATCH;
				end else if (sw_restart) begin
					err_d    = 1'b0;
					settle_d = SETTLE_ZERO;
					state_d  = ST_CHECK; // [RL6]
				end
			end
			default: begin
				state_d = ST_CHECK;
			end
		endcase
		// transmitter only in run; the drop cycle turns it off at once
		tx_d = (state_d == ST_RUN); // [RL4] [RL5]
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q         <= ST_CHECK;
			settle_q        <= SETTLE_ZERO;
			id_read_req_q   <= 1'b0;
			id_addr_q       <= ID_ADDR;
			tx_enable_q     <= 1'b0;
			image_start_q   <= 1'b0;
			reconnect_irq_q <= 1'b0;
			error_status_q  <= 1'b0;
		end else begin
			state_q         <= state_d;
			settle_q        <= settle_d;
			id_read_req_q   <= req_d;
			id_addr_q       <= addr_d;
			tx_enable_q     <= tx_d;
			image_start_q   <= start_d;
			reconnect_irq_q <= irq_d;
			error_status_q  <= err_d;
		end
	end

	// link domain: reset and enable cross as levels through two flops each
	logic rst_l1_q;
	logic rst_l_q;
	logic txen_l1_q;

	always_ff @(posedge pix_clk) begin
		rst_l1_q <= rst;
		rst_l_q  <= rst_l1_q;
	end

	always_ff @(posedge pix_clk) begin
		if (rst_l_q) begin
			txen_l1_q       <= 1'b0;
			tx_enable_pix_q <= 1'b0;
		end else begin
			txen_l1_q       <= tx_enable_q;
			tx_enable_pix_q <= txen_l1_q; // [RL3] [RL4]
		end
	end

	// transmitter state reported back to mclk for software visibility
	logic run_m1_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			run_m1_q     <= 1'b0;
			tx_running_q <= 1'b0;
		end else begin
			run_m1_q     <= tx_enable_pix_q;
			tx_running_q <= run_m1_q;
		end
	end

	// embedded checks
	sequence id_good_s;
		state_q == ST_WAIT_ID && pres_s_q && id_done && id_ack && id_digital;
	endsequence

	sequence id_bad_s;
		state_q == ST_WAIT_ID && pres_s_q && id_done && !(id_ack && id_digital);
	endsequence

	AST_START_CHECK: assert property (@(posedge mclk) // [RL1]
		rst |=> state_q == ST_CHECK && !tx_enable_q && !id_read_req_q)
		else $error("sequencer did not restart at presence check");

	AST_READ_ADDR: assert property (@(posedge mclk) disable iff (rst) // [RL2]
		id_read_req_q |-> id_addr_q == ID_ADDR && $past(pres_s_q, 2))
		else $error("identification read without presence or wrong address");

	AST_TX_ON: assert property (@(posedge mclk) disable iff (rst) // [RL3]
		id_good_s |=> tx_enable_q && image_start_q ##1 !image_start_q)
		else $error("transmitter not enabled after digital identification");

	AST_TX_OFF: assert property (@(posedge mclk) disable iff (rst) // [RL4]
		tx_enable_q && !pres_s_q |=> !tx_enable_q)
		else $error("transmitter not disabled on presence loss");

	AST_NO_REENABLE: assert property (@(posedge mclk) disable iff (rst) // [RL5]
		state_q == ST_WATCH && pres_s_q && !sw_restart |=> !tx_enable_q [*3])
		else $error("transmitter re-enabled on reconnect");

	AST_RECONNECT_IRQ: assert property (@(posedge mclk) disable iff (rst) // [RL6]
		state_q == ST_WATCH && pres_s_q |=> reconnect_irq_q && state_q == ST_HOLD)
		else $error("reconnect did not raise interrupt");

	AST_ANALOG: assert property (@(posedge mclk) disable iff (rst) // [RL7]
		id_bad_s |=> error_status_q && !tx_enable_q && state_q == ST_ANALOG)
		else $error("analogue monitor not reported");

	AST_ANALOG_UNPLUG: assert property (@(posedge mclk) disable iff (rst) // [RL8]
		state_q == ST_ANALOG && !pres_s_q |=> state_q == ST_WATCH && error_status_q)
		else $error("incompatible monitor removal not tracked");

	AST_INCOMPAT_RETURN: assert property (@(posedge mclk) disable iff (rst) // [RL9]
		state_q == ST_WATCH && error_status_q && pres_s_q |=> reconnect_irq_q)
		else $error("return after incompatible monitor not flagged");

	AST_SYNC_DEPTH: assert property (@(posedge mclk) disable iff (rst) // [RL17]
		$rose(pres_s_q) |-> $past(presence_in, 2))
		else $error("presence used without two synchroniser stages");

	AST_IRQ_PENDING: assert property (@(posedge mclk) disable iff (rst) // [RL18]
		reconnect_irq_q && !irq_clear |=> reconnect_irq_q)
		else $error("pending reconnect interrupt lost");

	AST_LINK_OFF: assert property (@(posedge pix_clk) disable iff (rst_l_q) // [RL4]
		!tx_enable_q [*3] |=> !tx_enable_pix_q)
		else $error("link-side transmitter enable stuck on");

	// settle finished: the presence decision is taken on this cycle
	sequence check_done_s;
		state_q == ST_CHECK && settle_q == SETTLE_CYCLES;
	endsequence

	AST_PRESENT_READ: assert property (@(posedge mclk) disable iff (rst) // [RL1]
		check_done_s and pres_s_q |=> state_q == ST_READ ##1 id_read_req_q)
		else $error("present monitor not read after settle");

	AST_CHECK_QUIET: assert property (@(posedge mclk) disable iff (rst) // [RL1]
		state_q == ST_CHECK |-> !tx_enable_q && !id_read_req_q)
		else $error("activity before presence confirmed");

	AST_REQ_PULSE: assert property (@(posedge mclk) disable iff (rst) // [RL2]
		id_read_req_q |=> !id_read_req_q)
		else $error("identification request longer than one cycle");

	AST_IMG_PULSE: assert property (@(posedge mclk) disable iff (rst) // [RL3]
		image_start_q |=> !image_start_q)
		else $error("image start longer than one cycle");

	AST_TX_ONLY_RUN: assert property (@(posedge mclk) disable iff (rst) // [RL5]
		tx_enable_q |-> state_q == ST_RUN)
		else $error("transmitter on outside normal display");

	AST_HOLD_NO_TX: assert property (@(posedge mclk) disable iff (rst) // [RL5]
		state_q == ST_HOLD |-> !tx_enable_q)
		else $error("transmitter on while reconnect pending");

	AST_RESTART: assert property (@(posedge mclk) disable iff (rst) // [RL6]
		state_q == ST_HOLD && pres_s_q && sw_restart |=> state_q == ST_CHECK && !error_status_q)
		else $error("software restart did not repeat identification");

	AST_ABSENT_ERR: assert property (@(posedge mclk) disable iff (rst) // [RL7]
		check_done_s and !pres_s_q |=> error_status_q && state_q == ST_WATCH)
		else $error("missing presence not reported");

	// the report must stand until software restarts the sequence
	AST_ERR_HELD: assert property (@(posedge mclk) disable iff (rst) // [RL8]
		error_status_q && !(state_q == ST_HOLD && sw_restart) |=> error_status_q)
		else $error("error status dropped before restart");

endmodule
`default_nettype wire

// file: design/hotplug_pkg.sv
// constants and state codes for the digital-only display hot-plug sequencer
// assumes one importer: the sequencer top and its embedded checks
`default_nettype none
package hotplug_pkg;
	// bus address of the display identification structure
	localparam logic [7:0] ID_ADDR       = 8'ha2;
	// presence comparator trip point, informational, set by the analogue side
	localparam int         PRESENCE_MV   = 2000;
	// cycles allowed after reset for the presence synchroniser to fill
	localparam logic [1:0] SETTLE_CYCLES = 2'h3;
	localparam logic [1:0] SETTLE_ZERO   = 2'h0;
	localparam logic [1:0] SETTLE_STEP   = 2'h1;

	// sequencer states
	typedef enum logic [2:0] {
		ST_CHECK   = 3'b000, // settle, then test presence
		ST_READ    = 3'b001, // issue identification read
		ST_WAIT_ID = 3'b010, // wait for read outcome
		ST_RUN     = 3'b011, // transmitter on, normal display
		ST_ANALOG  = 3'b100, // incompatible monitor, wait for unplug
		ST_WATCH   = 3'b101, // unplugged, wait for presence return
		ST_HOLD    = 3'b110  // reconnect flagged, wait for software restart
	} seq_state_t;
endpackage
`default_nettype wire

// file: tb/monitor_model.sv
// behavioural attached monitor: supply line and identification answers
// assumes the bench steers plug, answer kind and answer latency on mclk
`default_nettype none
module monitor_model (
	input  wire logic       mclk,
	input  wire logic       pix_clk,
	input  wire logic       shift_on,
	input  wire logic       plug,
	input  wire logic [1:0] kind,
	input  wire logic [3:0] lat,
	input  wire logic       id_read_req_q,
	output logic            presence_in,
	output logic            id_done,
	output logic            id_ack,
	output logic            id_digital,
	output logic            panel_on_q,
	output logic [1:0]      disp_pwr_q
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q;
	logic       busy_q;
	logic       rx_on_q;
	// powered up with receiver off and nothing answered
	initial begin
		{presence_in, id_done, id_ack, id_digital} = 4'h0;
		{cnt_q, busy_q, rx_on_q} = 6'h00;
		{panel_on_q, disp_pwr_q} = 3'h3;
	end
	// panel follows the shift clock enable; shift_on stands in for both h and v sync
	always @(posedge pix_clk) begin
		if (!plug || !rx_on_q) begin
			panel_on_q <= 1'b0;
			disp_pwr_q <= 2'h3;
		end else begin
			panel_on_q <= shift_on;
			case ({shift_on, shift_on})
				2'b11:   disp_pwr_q <= 2'h0; // on
				2'b10:   disp_pwr_q <= 2'h1; // standby
				2'b01:   disp_pwr_q <= 2'h2; // suspend
				default: disp_pwr_q <= 2'h3; // off
			endcase
		end
	end
	// kind 0 digital, 1 analogue, 2 silent; flags churn when unqualified
	always @(posedge mclk) begin
		presence_in <= plug;
		id_done     <= 1'b0;
		id_ack      <= ~id_ack;
		id_digital  <= ~id_digital;
		if (!plug) begin
			busy_q  <= 1'b0;
			rx_on_q <= 1'b0;
		end else if (id_read_req_q) begin
			busy_q <= 1'b1;
			cnt_q  <= lat;
		end else if (busy_q && cnt_q == 4'h0) begin
			busy_q     <= 1'b0;
			id_done    <= 1'b1;
			id_ack     <= (kind != 2'h2);
			id_digital <= (kind == 2'h0);
			rx_on_q    <= (kind == 2'h0);
		end else if (busy_q) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
endmodule
`default_nettype wire

// file: tb/hotplug_sequencer_test.sv
// self-checking bench for the hot-plug sequencer beside a monitor model
// assumes mclk 25 ns and a free pixel clock of 125 ns
`default_nettype none
module hotplug_sequencer_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int REQ = 0, TX = 1, IMG = 2, IRQ = 3, ERR = 4, RUN = 5, PIX = 6, PNL = 7;
	logic       mclk = 1'b0, pix_clk = 1'b0, rst = 1'b1, plug = 1'b1;
	logic       irq_clear = 1'b0, sw_restart = 1'b0;
	logic [1:0] kind = 2'h0;
	logic [3:0] lat = 4'h1;
	logic       presence_in, id_done, id_ack, id_digital, id_read_req_q, tx_enable_q;
	logic       tx_enable_pix_q, image_start_q, reconnect_irq_q, error_status_q, tx_running_q;
	logic [7:0] id_addr_q;
	logic       panel_on_q;
	logic [1:0] disp_pwr_q;
	wire  [7:0] obs = {panel_on_q, tx_enable_pix_q, tx_running_q, error_status_q, reconnect_irq_q,
		image_start_q, tx_enable_q, id_read_req_q};
	int         error_cnt = 0, checked = 0, reqs = 0;
	always #12.5 mclk = ~mclk;
	initial #3.3 forever #62.5 pix_clk = ~pix_clk;
	always @(posedge mclk) if (id_read_req_q === 1'b1) reqs <= reqs + 1;
	hotplug_sequencer DUT (.mclk, .rst, .pix_clk, .presence_in, .id_done, .id_ack, .id_digital,
		.irq_clear, .sw_restart, .id_read_req_q, .id_addr_q, .tx_enable_q, .tx_enable_pix_q,
		.image_start_q, .reconnect_irq_q, .error_status_q, .tx_running_q);
	monitor_model partner (.mclk, .pix_clk, .shift_on(tx_enable_pix_q), .plug, .kind, .lat,
		.id_read_req_q, .presence_in, .id_done, .id_ack, .id_digital, .panel_on_q,
		.disp_pwr_q);
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk1(input string name, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	// bounded poll of one output, sampled just after each edge
	task automatic wait_bit(input int i, input logic v, input int n);
		repeat (n) begin
			@(posedge mclk);
			#1;
			if (obs[i] === v) return;
		end
		chk1($sformatf("output %0d wait", i), v, obs[i]);
		end_of_test();
	endtask
	// 16 edges, not 5: the pixel side needs reset seen over its own flops
	task automatic do_reset();
		@(posedge mclk) rst <= 1'b1;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
	endtask
	task automatic kick(input logic restart);
		@(posedge mclk);
		if (restart) sw_restart <= 1'b1;
		else irq_clear <= 1'b1;
		@(posedge mclk);
		{sw_restart, irq_clear} <= 2'h0;
	endtask
	// supply present: read at a2h, digital answer starts the transmitter
	task automatic s_digital();
		do_reset();
		wait_bit(REQ, 1'b1, 12);
		chk8("id_addr_q", 8'ha2, id_addr_q);
		wait_bit(IMG, 1'b1, 12);
		chk1("tx_enable_q", 1'b1, tx_enable_q);
		@(posedge mclk);
		#1;
		chk1("image_start_q", 1'b0, image_start_q);
		wait_bit(PIX, 1'b1, 20);
		wait_bit(RUN, 1'b1, 8);
		wait_bit(PNL, 1'b1, 12);
		chk8("disp_pwr_q", 8'h00, {6'h00, disp_pwr_q});
	endtask
	// unplug stops the transmitter; replug only flags software
	task automatic s_unplug();
		@(posedge mclk) plug <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk1("tx_enable_q", 1'b1, tx_enable_q);
		wait_bit(TX, 1'b0, 6);
		wait_bit(PIX, 1'b0, 30);
		wait_bit(PNL, 1'b0, 12);
		chk8("disp_pwr_q", 8'h03, {6'h00, disp_pwr_q});
		@(posedge mclk) plug <= 1'b1;
		wait_bit(IRQ, 1'b1, 8);
		repeat (10) @(posedge mclk);
		#1;
		chk1("tx_enable_q", 1'b0, tx_enable_q);
		chk1("reconnect_irq_q", 1'b1, reconnect_irq_q);
		kick(1'b0);
		wait_bit(IRQ, 1'b0, 3);
	endtask
	// restart into an analogue or silent monitor; error, then unplug and replug
	task automatic s_analog(input logic [1:0] k, input logic [3:0] l);
		@(posedge mclk);
		kind <= k;
		lat <= l;
		kick(1'b1);
		wait_bit(REQ, 1'b1, 12);
		chk1("error_status_q", 1'b0, error_status_q);
		wait_bit(ERR, 1'b1, 24);
		chk1("tx_enable_q", 1'b0, tx_enable_q);
		@(posedge mclk) plug <= 1'b0;
		repeat (8) @(posedge mclk);
		#1;
		chk1("reconnect_irq_q", 1'b0, reconnect_irq_q);
		@(posedge mclk) plug <= 1'b1;
		wait_bit(IRQ, 1'b1, 8);
		kick(1'b0);
		wait_bit(IRQ, 1'b0, 3);
	endtask
	// second reset with no supply: error and no read at all
	task automatic s_absent();
		int n;
		@(posedge mclk) plug <= 1'b0;
		n = reqs;
		do_reset();
		wait_bit(ERR, 1'b1, 12);
		chk1("no read issued", 1'b1, reqs == n);
		@(posedge mclk) plug <= 1'b1;
		wait_bit(IRQ, 1'b1, 8);
	endtask
	initial begin
		s_digital();
		s_unplug();
		s_analog(2'h1, 4'h1);
		s_analog(2'h2, 4'h9);
		s_absent();
		end_of_test();
	end
endmodule
`default_nettype wire
